// ===== dmscp_top.sv
/*
 Dual mode serial control port: twenty 8-bit control registers written by
 a 3-wire shift port or read and written as a two-wire bus slave.
 Assumes clk is free running at 10 MHz; the shift clock only runs inside
 frames; the two-wire bus is slow enough to oversample on clk.
*/
`default_nettype none

module dmscp_top
    import dmscp_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic power_down_n,
    input wire logic i2c_mode_strap,
    input wire logic device_addr_strap,
    input wire logic serial_select_n,
    input wire logic serial_shift_clock,
    input wire logic serial_data_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic [DMSCP_NREG*8-1:0] ctrl_regs,
    output logic reg_write_strobe,
    output logic [4:0] reg_write_index
);

    // Link domain: 3-wire receiver on the shift clock

    logic [4:0] bit_cnt_q;
    logic [14:0] shift_q;
    logic [15:0] frame_q;
    logic frame_tog_q;
    wire last_bit = (bit_cnt_q == 5'(DMSCP_FRAME_BITS - 1));

    // Select high clears the count, so a short frame never completes
    always_ff @(posedge serial_shift_clock or posedge serial_select_n) begin
        if (serial_select_n) begin
            bit_cnt_q <= 5'h00;
        end else if (bit_cnt_q != 5'(DMSCP_FRAME_BITS)) begin
            bit_cnt_q <= bit_cnt_q + 5'h01;
        end
    end

    always_ff @(posedge serial_shift_clock or negedge nrst) begin
        if (!nrst) begin
            shift_q <= 15'h0000;
        end else begin
            shift_q <= {shift_q[13:0], serial_data_in};
        end
    end

    // Frame held here until the next 16th edge; a toggle flags it
    always_ff @(posedge serial_shift_clock or negedge nrst) begin
        if (!nrst) begin
            frame_q <= 16'h0000;
            frame_tog_q <= 1'b0;
        end else if (last_bit) begin
            frame_q <= {shift_q, serial_data_in};
            frame_tog_q <= ~frame_tog_q;
        end
    end

    // System domain: pin synchronisers

    localparam int SN = 6;
    localparam int S_PDN = 0;
    localparam int S_MODE = 1;
    localparam int S_DEV = 2;
    localparam int S_SCL = 3;
    localparam int S_SDA = 4;
    localparam int S_TOG = 5;

    // Bus pins start at their idle high level, so no false edge after reset
    localparam logic [SN-1:0] SYNC_IDLE = 6'h18;
    logic [SN-1:0] sync1_q;
    logic [SN-1:0] sync2_q;
    logic scl_p_q;
    logic sda_p_q;
    logic tog_p_q;
    wire [SN-1:0] raw_in = {frame_tog_q, sda_in, scl_in,
                            device_addr_strap, i2c_mode_strap, power_down_n};

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync1_q <= SYNC_IDLE;
            sync2_q <= SYNC_IDLE;
        end else begin
            sync1_q <= raw_in;
            sync2_q <= sync1_q;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
            tog_p_q <= 1'b0;
        end else begin
            scl_p_q <= sync2_q[S_SCL];
            sda_p_q <= sync2_q[S_SDA];
            tog_p_q <= sync2_q[S_TOG];
        end
    end

    wire pd_active = ~sync2_q[S_PDN];
    wire mode_i2c = sync2_q[S_MODE];
    wire scl = sync2_q[S_SCL];
    wire sda = sync2_q[S_SDA];

    // Bus conditions; start and stop only while the clock is high
    wire scl_rise = scl & ~scl_p_q;
    wire scl_fall = ~scl & scl_p_q;
    wire start_c = scl & scl_p_q & sda_p_q & ~sda;
    wire stop_c = scl & scl_p_q & ~sda_p_q & sda;

    // 3-wire write, accepted only with valid code and direction

    wire frame_new = sync2_q[S_TOG] ^ tog_p_q;
    wire frame_ok = (frame_q[15:DMSCP_F_CODE_LSB] == DMSCP_CHIP_CODE)
                  && (frame_q[DMSCP_F_DIR] == DMSCP_DIR_WRITE);
    wire wr3_en = frame_new & frame_ok & ~mode_i2c;
    wire [4:0] wr3_idx = frame_q[DMSCP_F_IDX_LSB+4:DMSCP_F_IDX_LSB];
    wire [7:0] wr3_data = frame_q[7:0];

    // Two-wire slave

    dmscp_state_t state_q;
    dmscp_state_t state_d;
    dmscp_kind_t kind_q;
    dmscp_kind_t kind_d;
    logic [3:0] bcnt_q;
    logic [3:0] bcnt_d;
    logic [7:0] sh_q;
    logic [7:0] sh_d;
    logic [4:0] ptr_q;
    logic [4:0] ptr_d;
    logic rd_q;
    logic rd_d;
    logic oe_q;
    logic oe_d;
    logic i2c_we;

    logic [7:0] regs_q [DMSCP_NREG];

    wire addr_hit = (sh_q[7:2] == DMSCP_ADDR_HI)
                  && (sh_q[1] == sync2_q[S_DEV]);
    wire [4:0] ptr_inc = (ptr_q == DMSCP_LAST_IDX) ? 5'h00
                                                   : ptr_q + 5'h01;
    wire ptr_in_map = (ptr_q <= DMSCP_LAST_IDX);
    wire [7:0] rd_byte = ptr_in_map ? regs_q[ptr_q] : 8'h00;
    wire byte_done = scl_fall && (bcnt_q == 4'h8);

    always_comb begin
        state_d = state_q;
        kind_d = kind_q;
        bcnt_d = bcnt_q;
        sh_d = sh_q;
        ptr_d = ptr_q;
        rd_d = rd_q;
        oe_d = oe_q;
        i2c_we = 1'b0;
        if (!mode_i2c) begin
            state_d = DMSCP_ST_IDLE;
            oe_d = 1'b0;
        end else if (start_c) begin
            // Repeated start too: back to header reception
            state_d = DMSCP_ST_RX;
            kind_d = DMSCP_K_ADDR;
            bcnt_d = 4'h0;
            oe_d = 1'b0;
        end else if (stop_c) begin
            state_d = DMSCP_ST_IDLE;
            oe_d = 1'b0;
        end else begin
            case (state_q)
                DMSCP_ST_RX: begin
                    if (scl_rise && bcnt_q != 4'h8) begin
                        sh_d = {sh_q[6:0], sda};
                        bcnt_d = bcnt_q + 4'h1;
                    end else if (byte_done) begin
                        bcnt_d = 4'h0;
                        state_d = DMSCP_ST_ACK;
                        oe_d = 1'b1;
                        kind_d = DMSCP_K_DATA;
                        case (kind_q)
                            DMSCP_K_ADDR: begin
                                kind_d = DMSCP_K_REG;
                                rd_d = sh_q[0];
                                if (!addr_hit) begin
                                    state_d = DMSCP_ST_IDLE;
                                    oe_d = 1'b0;
                                end
                            end
                            DMSCP_K_REG: begin
                                ptr_d = sh_q[4:0];
                            end
                            default: begin
                                i2c_we = 1'b1;
                                ptr_d = ptr_inc;
                            end
                        endcase
                    end
                end
                DMSCP_ST_ACK: begin
                    // Leave the line only after the ack clock falls
                    if (scl_fall) begin
                        oe_d = 1'b0;
                        state_d = DMSCP_ST_RX;
                        if (rd_q) begin
                            sh_d = rd_byte;
                            oe_d = ~rd_byte[7];
                            ptr_d = ptr_inc;
                            bcnt_d = 4'h1;
                            state_d = DMSCP_ST_TX;
                        end
                    end
                end
                DMSCP_ST_TX: begin
                    if (scl_fall) begin
                        if (bcnt_q == 4'h8) begin
                            oe_d = 1'b0;
                            state_d = DMSCP_ST_RACK;
                        end else begin
                            sh_d = {sh_q[6:0], 1'b0};
                            oe_d = ~sh_q[6];
                            bcnt_d = bcnt_q + 4'h1;
                        end
                    end
                end
                DMSCP_ST_RACK: begin
                    // Host ack asks for the next byte, no-ack ends it
                    if (scl_rise) begin
                        if (sda) begin
                            state_d = DMSCP_ST_IDLE;
                        end else begin
                            state_d = DMSCP_ST_ACK;
                        end
                    end
                end
                DMSCP_ST_IDLE: begin
                    oe_d = 1'b0;
                end
                default: begin
                    state_d = DMSCP_ST_IDLE;
                    oe_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= DMSCP_ST_IDLE;
            kind_q <= DMSCP_K_ADDR;
            bcnt_q <= 4'h0;
            sh_q <= 8'h00;
            rd_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            state_q <= state_d;
            kind_q <= kind_d;
            bcnt_q <= bcnt_d;
            sh_q <= sh_d;
            rd_q <= rd_d;
            oe_q <= oe_d;
        end
    end

    // Counter restarts at zero with the registers on power-down
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ptr_q <= 5'h00;
        end else if (pd_active) begin
            ptr_q <= 5'h00;
        end else begin
            ptr_q <= ptr_d;
        end
    end

    // Open-drain data: only ever pulled low
    assign sda_out = 1'b0;
    assign sda_oe = oe_q;

    // Register file

    wire wr_en = mode_i2c ? i2c_we : wr3_en;
    wire [4:0] wr_idx = mode_i2c ? ptr_q : wr3_idx;
    wire [7:0] wr_data = mode_i2c ? sh_q : wr3_data;
    wire wr_ok = wr_en & ~pd_active;

    genvar gi;
    generate
        for (gi = 0; gi < DMSCP_NREG; gi++) begin : g_reg
            localparam logic [4:0] IDX = 5'(gi);
            wire hit = wr_ok && (wr_idx == IDX);
            // Unused bits are masked so they always read zero
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    regs_q[gi] <= dmscp_reset_val(IDX);
                end else if (pd_active) begin
                    regs_q[gi] <= dmscp_reset_val(IDX);
                end else if (hit) begin
                    regs_q[gi] <= wr_data & dmscp_wmask(IDX);
                end
            end
            assign ctrl_regs[gi*8 +: 8] = regs_q[gi];
        end
    endgenerate

    // Write notice for the blocks that act on register changes
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reg_write_strobe <= 1'b0;
            reg_write_index <= 5'h00;
        end else begin
            reg_write_strobe <= wr_ok && (wr_idx <= DMSCP_LAST_IDX);
            reg_write_index <= wr_idx;
        end
    end

endmodule : dmscp_top

`default_nettype wire

// ===== dmscp_pkg.sv
/*
 Constants shared by the dual mode serial control port: register map size,
 reset values, writable-bit masks, frame layout and bus address fields.
 Assumes a 10 MHz system clock and the serial pins of the control port.
*/
`default_nettype none

package dmscp_pkg;

    localparam int DMSCP_NREG = 20;
    localparam logic [4:0] DMSCP_LAST_IDX = 5'h13;

    // 3-wire frame layout, bit 15 arrives first
    localparam int DMSCP_FRAME_BITS = 16;
    localparam int DMSCP_F_CODE_LSB = 14;
    localparam int DMSCP_F_DIR = 13;
    localparam int DMSCP_F_IDX_LSB = 8;
    localparam logic [1:0] DMSCP_CHIP_CODE = 2'h1;
    localparam logic DMSCP_DIR_WRITE = 1'b1;

    // Two-wire slave address, upper six bits
    localparam logic [5:0] DMSCP_ADDR_HI = 6'h08;

    // Rate limits kept by the host
    localparam int DMSCP_CLK_HZ = 10_000_000;
    localparam int DMSCP_SHIFT_CLK_MAX_HZ = 5_000_000;
    localparam int DMSCP_BUS_CLK_MAX_HZ = 400_000;

    // Reset values: zero, and the three registers that reset to other values
    localparam logic [7:0] DMSCP_RST_ZERO = 8'h00;
    localparam logic [7:0] DMSCP_RST_RATE = 8'h80;
    localparam logic [7:0] DMSCP_RST_FMT = 8'h02;
    localparam logic [7:0] DMSCP_RST_FILT = 8'h21;

    // Writable bits; unused bits always read zero
    localparam logic [7:0] DMSCP_WM_ALL = 8'hff;
    localparam logic [7:0] DMSCP_WM_B6 = 8'hbf;
    localparam logic [7:0] DMSCP_WM_B7 = 8'h7f;
    localparam logic [7:0] DMSCP_WM_LO4 = 8'h0f;
    localparam logic [7:0] DMSCP_WM_LO6 = 8'h3f;
    localparam logic [7:0] DMSCP_WM_LO3 = 8'h07;
    localparam logic [7:0] DMSCP_WM_NONE = 8'h00;

    function automatic logic [7:0] dmscp_reset_val(input logic [4:0] idx);
        case (idx)
            5'h01: dmscp_reset_val = DMSCP_RST_RATE;
            5'h03: dmscp_reset_val = DMSCP_RST_FMT;
            5'h04: dmscp_reset_val = DMSCP_RST_FILT;
            default: dmscp_reset_val = DMSCP_RST_ZERO;
        endcase
    endfunction : dmscp_reset_val

    function automatic logic [7:0] dmscp_wmask(input logic [4:0] idx);
        case (idx)
            5'h02: dmscp_wmask = DMSCP_WM_B6;
            5'h03, 5'h08, 5'h0e, 5'h13: dmscp_wmask = DMSCP_WM_B7;
            5'h09: dmscp_wmask = DMSCP_WM_LO4;
            5'h0a, 5'h0b, 5'h0c: dmscp_wmask = DMSCP_WM_NONE;
            5'h10: dmscp_wmask = DMSCP_WM_LO6;
            5'h11: dmscp_wmask = DMSCP_WM_LO3;
            default: dmscp_wmask = DMSCP_WM_ALL;
        endcase
    endfunction : dmscp_wmask

    typedef enum logic [2:0] {
        DMSCP_ST_IDLE,
        DMSCP_ST_RX,
        DMSCP_ST_ACK,
        DMSCP_ST_TX,
        DMSCP_ST_RACK
    } dmscp_state_t;

    typedef enum logic [1:0] {
        DMSCP_K_ADDR,
        DMSCP_K_REG,
        DMSCP_K_DATA
    } dmscp_kind_t;

endpackage : dmscp_pkg

`default_nettype wire

// ===== dmscp_properties.sv
/* Port checker for the serial control port top.
 Bound to dmscp_top by the bench; sees its ports only. */
`default_nettype none
module dmscp_properties
    import dmscp_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic power_down_n,
    input wire logic i2c_mode_strap,
    input wire logic device_addr_strap,
    input wire logic serial_select_n,
    input wire logic serial_shift_clock,
    input wire logic serial_data_in,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic [DMSCP_NREG*8-1:0] ctrl_regs,
    input wire logic reg_write_strobe,
    input wire logic [4:0] reg_write_index
);
    localparam logic [DMSCP_NREG*8-1:0] DEFS =
        {120'h0, 8'h21, 8'h02, 8'h00, 8'h80, 8'h00};
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    a_drive_low: assert property (
        sda_out == 1'b0) else $error("sda_out not low");
    a_oe_scl_low: assert property (
        $changed(sda_oe) |-> !scl_in && !$past(scl_in))
        else $error("sda_oe moved while scl high");
    a_oe_stands: assert property (
        $rose(sda_oe) |=> sda_oe [*8]) else $error("drive dropped early");
    a_pd_defaults: assert property (
        (!power_down_n) [*5] |-> ctrl_regs == DEFS)
        else $error("registers not at defaults");
    a_pd_frozen: assert property (
        (!power_down_n) [*6] |-> !reg_write_strobe && $stable(ctrl_regs))
        else $error("write during power-down");
    a_change_strobe: assert property (
        $changed(ctrl_regs) && power_down_n && $past(power_down_n, 6)
        |-> reg_write_strobe) else $error("change without strobe");
    a_idle_quiet: assert property (
        (serial_select_n && !i2c_mode_strap) [*8] |-> !reg_write_strobe)
        else $error("strobe without frame");
    a_3w_no_drive: assert property (
        (!i2c_mode_strap) [*8] |-> !sda_oe) else $error("sda driven");
    a_strobe_index: assert property (
        reg_write_strobe |-> reg_write_index <= DMSCP_LAST_IDX)
        else $error("strobe index out of map");
    c_3w_write: cover property (reg_write_strobe && !i2c_mode_strap);
    c_bus_write: cover property (reg_write_strobe && i2c_mode_strap);
    c_bus_drive: cover property ($rose(sda_oe));
endmodule : dmscp_properties
`default_nettype wire

// ===== dmscp_host.sv
/* Host model: shifts 3-wire frames and masters the two-wire bus.
 Assumes the bench forms the wired sda level with a pull-up. */
`default_nettype none
module dmscp_host (
    output logic serial_select_n,
    output logic serial_shift_clock,
    output logic serial_data_in,
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int HALF = 128; // Kept under the shift clock ceiling
    localparam int Q = 625; // Quarter bit at 400 kHz
    initial begin
        serial_select_n = 1'b0;
        serial_shift_clock = 1'b0;
        serial_data_in = 1'b0;
        scl = 1'b1;
        sda_low = 1'b0;
        // A real select edge clears the frame counter before first use
        #1 serial_select_n = 1'b1;
    end
    task automatic frame3(input logic [15:0] f, input int n);
        serial_select_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            serial_data_in = f[15-i];
            #HALF serial_shift_clock = 1'b1;
            #HALF serial_shift_clock = 1'b0;
        end
        #HALF serial_select_n = 1'b1;
        serial_data_in = ~serial_data_in;
        #HALF;
    endtask : frame3
    task automatic bit_out(input logic b);
        sda_low = !b;
        #Q scl = 1'b1;
        #(2*Q) scl = 1'b0;
        #Q;
    endtask : bit_out
    task automatic bit_in(output logic b);
        sda_low = 1'b0;
        #Q scl = 1'b1;
        #Q b = sda;
        #Q scl = 1'b0;
        #Q;
    endtask : bit_in
    task automatic start;
        sda_low = 1'b0;
        #Q scl = 1'b1;
        #Q sda_low = 1'b1;
        #Q scl = 1'b0;
        #Q;
    endtask : start
    task automatic stop;
        sda_low = 1'b1;
        #Q scl = 1'b1;
        #Q sda_low = 1'b0;
        #Q;
    endtask : stop
    task automatic byte_w(input logic [7:0] d, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) bit_out(d[i]);
        bit_in(a);
        ack = !a;
    endtask : byte_w
    task automatic byte_r(output logic [7:0] d, input logic more);
        for (int i = 7; i >= 0; i--) bit_in(d[i]);
        bit_out(!more);
    endtask : byte_r
endmodule : dmscp_host
`default_nettype wire

// ===== dmscp_top_tb.sv
/* Bench for the serial control port: reset, 3-wire frames, power-down,
 two-wire writes and reads. Assumes dmscp_host and the bound checker. */
`default_nettype none
module dmscp_top_tb
    import dmscp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk;
    logic nrst;
    logic power_down_n;
    logic i2c_mode_strap;
    logic device_addr_strap;
    logic serial_select_n;
    logic serial_shift_clock;
    logic serial_data_in;
    logic scl;
    logic sda_low;
    logic sda_out;
    logic sda_oe;
    logic [DMSCP_NREG*8-1:0] ctrl_regs;
    logic reg_write_strobe;
    logic [4:0] reg_write_index;
    logic [7:0] exp [DMSCP_NREG];
    int errors;
    int checked;
    int strobes;
    logic [4:0] strobe_idx;
    wire logic sda_w = ~(sda_oe | sda_low); // Pull-up when nobody pulls
    dmscp_top i_dut (
        .clk(clk),
        .nrst(nrst),
        .power_down_n(power_down_n),
        .i2c_mode_strap(i2c_mode_strap),
        .device_addr_strap(device_addr_strap),
        .serial_select_n(serial_select_n),
        .serial_shift_clock(serial_shift_clock),
        .serial_data_in(serial_data_in),
        .scl_in(scl),
        .sda_in(sda_w),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .ctrl_regs(ctrl_regs),
        .reg_write_strobe(reg_write_strobe),
        .reg_write_index(reg_write_index)
    );
    dmscp_host i_host (
        .serial_select_n(serial_select_n),
        .serial_shift_clock(serial_shift_clock),
        .serial_data_in(serial_data_in),
        .scl(scl),
        .sda_low(sda_low),
        .sda(sda_w)
    );
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] want);
        checked++;
        if (seen !== want) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, want, seen);
        end
    endtask : check
    task automatic chk_regs;
        for (int i = 0; i < DMSCP_NREG; i++)
            check("register", ctrl_regs[8*i+:8], exp[i]);
    endtask : chk_regs
    // Strobe lasts one cycle; counted mid-cycle so none slips by
    always @(negedge clk) begin
        if (reg_write_strobe === 1'b1) begin
            strobes <= strobes + 1;
            strobe_idx <= reg_write_index;
        end
    end
    task automatic t3w(input logic [15:0] f, input int n,
                       input logic [7:0] want);
        int n0;
        n0 = strobes;
        i_host.frame3(f, n);
        repeat (6) @(negedge clk);
        check("strobes", 8'(strobes - n0), want);
        if (want != 8'h00) begin
            check("index", {3'h0, strobe_idx}, {3'h0, f[12:8]});
        end
    endtask : t3w
    task automatic hw(input logic [7:0] b);
        logic a;
        i_host.byte_w(b, a);
        check("ack", {7'h0, a}, 8'h01);
    endtask : hw
    task automatic rd(input logic [7:0] want, input logic more);
        logic [7:0] d;
        i_host.byte_r(d, more);
        check("read byte", d, want);
    endtask : rd
    task automatic t_3wire;
        t3w({2'b01, 1'b1, 5'h05, 8'ha5}, 16, 8'h01);
        exp[5] = 8'ha5;
        t3w({2'b01, 1'b1, 5'h0b, 8'hff}, 16, 8'h01);
        t3w({2'b10, 1'b1, 5'h06, 8'h3c}, 16, 8'h00);
        t3w({2'b01, 1'b0, 5'h06, 8'h3c}, 16, 8'h00);
        t3w({2'b01, 1'b1, 5'h06, 8'h3c}, 15, 8'h00);
        chk_regs;
    endtask : t_3wire
    task automatic t_pdown;
        @(negedge clk);
        power_down_n = 1'b0;
        exp[5] = 8'h00;
        t3w({2'b01, 1'b1, 5'h07, 8'h11}, 16, 8'h00);
        repeat (6) @(negedge clk);
        chk_regs;
        power_down_n = 1'b1;
        repeat (4) @(negedge clk);
    endtask : t_pdown
    task automatic t_bus_write;
        @(negedge clk);
        i2c_mode_strap = 1'b1;
        repeat (4) @(negedge clk);
        t3w({2'b01, 1'b1, 5'h06, 8'h3c}, 16, 8'h00);
        i_host.start;
        hw(8'h22);
        hw(8'h12);
        hw(8'h11);
        hw(8'h22);
        hw(8'h33);
        i_host.stop;
        exp[18] = 8'h11;
        exp[19] = 8'h22;
        exp[0] = 8'h33;
        repeat (8) @(negedge clk);
        chk_regs;
    endtask : t_bus_write
    task automatic t_bad_addr;
        logic a;
        i_host.start;
        i_host.byte_w(8'h20, a);
        check("no ack", {7'h0, a}, 8'h00);
        i_host.stop;
    endtask : t_bad_addr
    task automatic t_bus_read;
        i_host.start;
        hw(8'h22);
        hw(8'h12);
        i_host.start;
        hw(8'h23);
        rd(exp[18], 1'b1);
        rd(exp[19], 1'b1);
        rd(exp[0], 1'b0);
        i_host.stop;
        check("released", {7'h0, sda_oe}, 8'h00);
        i_host.start;
        hw(8'h23);
        rd(exp[1], 1'b0);
        i_host.stop;
    endtask : t_bus_read
    task automatic summarize;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : summarize
    initial begin
        power_down_n = 1'b1;
        i2c_mode_strap = 1'b0;
        device_addr_strap = 1'b1;
        nrst = 1'b1;
        for (int i = 0; i < DMSCP_NREG; i++) exp[i] = DMSCP_RST_ZERO;
        exp[1] = DMSCP_RST_RATE;
        exp[3] = DMSCP_RST_FMT;
        exp[4] = DMSCP_RST_FILT;
        // A true falling edge, so the link-side flops see their reset
        #1 nrst = 1'b0;
        repeat (20) @(negedge clk);
        nrst = 1'b1;
        repeat (4) @(negedge clk);
        chk_regs;
        t_3wire;
        t_pdown;
        t_bus_write;
        t_bad_addr;
        t_bus_read;
        summarize;
    end
    initial begin
        #1_000_000;
        errors++;
        summarize;
    end
endmodule : dmscp_top_tb
bind dmscp_top dmscp_properties i_chk (
    .clk(clk), .nrst(nrst), .power_down_n(power_down_n),
    .i2c_mode_strap(i2c_mode_strap), .device_addr_strap(device_addr_strap),
    .serial_select_n(serial_select_n),
    .serial_shift_clock(serial_shift_clock),
    .serial_data_in(serial_data_in), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .ctrl_regs(ctrl_regs),
    .reg_write_strobe(reg_write_strobe), .reg_write_index(reg_write_index)
);
`default_nettype wire
